// file: rtl/rs_refresh_defs.svh
/*
  Constants of the refresh scheduler: timing figures, derived cycle counts,
  bank count, window sizes and postponement limits.
  Assumes a 20 MHz controller clock and one eight-bank channel.
*/
// Refresh rules of the device that the code cites as R01 to R25
// R01: Refresh only an idle bank; controller tracks each per-bank target itself.
// R02: Per-bank refresh waits all-bank cycle, per-bank cycle, precharge and act-act gaps.
// R03: Device blocks the target bank during per-bank refresh; others stay usable.
// R04: Device leaves the refreshed bank idle after a per-bank refresh.
// R05: After per-bank refresh wait its cycle before refresh or same-bank activate.
// R06: All-bank refresh hits every bank, needs all idle, never right after activate.
// R07: All-bank refresh waits all-bank cycle, per-bank cycle and precharge period.
// R08: After all-bank refresh banks idle; wait its cycle before activate or refresh.
// R09: Issue one refresh per average interval, with bounded flexibility.
// R10: Never more than eight postponed; gap at most nine intervals. The code only raises refresh_urgent at the limit; the credit keeps rising.
// R11: Up to eight pulled in give credit; more give none.
// R12: At most sixteen all-bank refreshes in any two intervals.
// R13: Self refresh entry allowed with up to eight postponed, total stays eight.
// R14: Postponed and pulled-in counts stay frozen during self refresh.
// R15: Per-bank: eight times eight postponed or pulled in, 128 per window.
// R16: Rate code selects interval multiplier; per-bank rate is one eighth.
// R17: Four-times rate: 2/3/4; two-times: 4/5/8; faster: 8/9/16.
// R18: Window is larger of two scaled intervals or sixteen all-bank cycles.
// R19: Entering two- or four-times rate zeroes the pulled-in count.
// R20: Controller may refresh faster than reported, using that rate's limits.
// R21: Bank counter zeroed at reset, self-refresh exit and all-bank refresh.
// R22: No second per-bank refresh to a bank before all eight got one.
// R23: Per-bank refresh carries its three-bit bank address.
// R24: All-bank refresh with nonzero counter clears it; rows advance after.
// R25: Signed credit counter, updated per interval and refresh, saturated by rate.
`ifndef RS_REFRESH_DEFS_SVH
`define RS_REFRESH_DEFS_SVH

`define RS_CLK_NS 50
`define RS_REFI_NS 3904
`define RS_RFCAB_NS 280
`define RS_RFCPB_NS 140
`define RS_RP_NS 18
`define RS_RRD_NS 10
// Average interval rounds down, least times round up
`define RS_REFI_CYC (`RS_REFI_NS / `RS_CLK_NS)
`define RS_RFCAB_CYC ((`RS_RFCAB_NS + `RS_CLK_NS - 1) / `RS_CLK_NS)
`define RS_RFCPB_CYC ((`RS_RFCPB_NS + `RS_CLK_NS - 1) / `RS_CLK_NS)
`define RS_RP_CYC ((`RS_RP_NS + `RS_CLK_NS - 1) / `RS_CLK_NS)
`define RS_RRD_CYC ((`RS_RRD_NS + `RS_CLK_NS - 1) / `RS_CLK_NS)

`define RS_NUM_BANKS 8
`define RS_PB_SHIFT 3
`define RS_WIN_RFC_MULT 16
`define RS_SLOTS 5
`define RS_LIM_X4 8'h02
`define RS_LIM_X2 8'h04
`define RS_LIM_STD 8'h08

`endif

// file: rtl/rs_refresh_pkg.sv
/*
  Types of the refresh scheduler: refresh-rate code encodings.
  Assumes the code is read from the device by other controller logic.
*/
package rs_refresh_pkg;

  typedef enum logic [2:0] {
    RS_RATE_LOW_LIMIT = 3'b000,
    RS_RATE_X4 = 3'b001,
    RS_RATE_X2 = 3'b010,
    RS_RATE_X1 = 3'b011,
    RS_RATE_HALF = 3'b100,
    RS_RATE_QUARTER = 3'b101,
    RS_RATE_QUARTER_B = 3'b110,
    RS_RATE_HIGH_LIMIT = 3'b111
  } rs_rate_t;

endpackage : rs_refresh_pkg

// file: rtl/rs_refresh_sched.sv
/*
  Refresh scheduler on the memory-controller side of one eight-bank channel.
  Tracks open banks from activate/precharge notices, keeps a signed refresh
  credit and issues all-bank or per-bank refresh commands into free slots.
  Assumes all inputs are synchronous to clk and that the command bus logic
  puts a refresh on the pins in the cycle its pulse is seen.
*/
`include "rs_refresh_defs.svh"

module rs_refresh_sched #(
  parameter int REFI_CYC = `RS_REFI_CYC,
  parameter int RFCAB_CYC = `RS_RFCAB_CYC,
  parameter int RFCPB_CYC = `RS_RFCPB_CYC,
  parameter int RP_CYC = `RS_RP_CYC,
  parameter int RRD_CYC = `RS_RRD_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] refresh_rate_code,
  input wire logic per_bank_mode,
  input wire logic pull_in_allow,
  input wire logic self_refresh_active,
  input wire logic self_refresh_exit_cmd,
  input wire logic cmd_slot_free,
  input wire logic act_issued,
  input wire logic [2:0] act_bank,
  input wire logic pre_issued,
  input wire logic [2:0] pre_bank,
  input wire logic pre_all,
  output logic all_bank_refresh_cmd,
  output logic per_bank_refresh_cmd,
  output logic bank_addr_bit0,
  output logic bank_addr_bit1,
  output logic bank_addr_bit2,
  output logic refresh_urgent,
  output logic [7:0] bank_blocked,
  output logic [7:0] refresh_credit
);

  localparam int NB = `RS_NUM_BANKS;
  localparam int NS = `RS_SLOTS;
  localparam logic [3:0] RFCAB_T = 4'(RFCAB_CYC);
  localparam logic [3:0] RFCPB_T = 4'(RFCPB_CYC);
  localparam logic [3:0] RP_T = 4'(RP_CYC);
  localparam logic [3:0] RRD_T = 4'(RRD_CYC);
  localparam logic [11:0] BASE4 = 12'(REFI_CYC * 4);
  localparam logic [11:0] RFC_WIN = 12'(RFCAB_CYC * `RS_WIN_RFC_MULT);

  ////////////////////////////////////////////////////////////////////////////
  // Rate decode

  logic [2:0] rate_shift;
  logic [7:0] lim_ab;
  logic [11:0] int_ab;
  logic [11:0] tick_len;
  logic [11:0] slot_len;
  logic signed [7:0] lim_c;
  logic [7:0] ref_max_c;
  logic [2:0] rate_code_reg;
  logic enter_slow;

  // Reported rate used as is; limit tables the colder codes clamp to 4x
  always_comb begin
    unique case (rs_refresh_pkg::rs_rate_t'(refresh_rate_code)) // R16 R20
      rs_refresh_pkg::RS_RATE_LOW_LIMIT: begin
        rate_shift = 3'h0;
        lim_ab = `RS_LIM_X4;
      end
      rs_refresh_pkg::RS_RATE_X4: begin
        rate_shift = 3'h0;
        lim_ab = `RS_LIM_X4; // R17
      end
      rs_refresh_pkg::RS_RATE_X2: begin
        rate_shift = 3'h1;
        lim_ab = `RS_LIM_X2; // R17
      end
      rs_refresh_pkg::RS_RATE_X1: begin
        rate_shift = 3'h2;
        lim_ab = `RS_LIM_STD;
      end
      rs_refresh_pkg::RS_RATE_HALF: begin
        rate_shift = 3'h3;
        lim_ab = `RS_LIM_STD;
      end
      rs_refresh_pkg::RS_RATE_QUARTER, rs_refresh_pkg::RS_RATE_QUARTER_B,
      rs_refresh_pkg::RS_RATE_HIGH_LIMIT: begin
        rate_shift = 3'h4;
        lim_ab = `RS_LIM_STD;
      end
    endcase
    int_ab = BASE4 >> rate_shift;
    // Per-bank refresh runs at eight times the all-bank rate
    tick_len = per_bank_mode ? (int_ab >> `RS_PB_SHIFT) : int_ab; // R16
    lim_c = per_bank_mode ? 8'(lim_ab << `RS_PB_SHIFT) : lim_ab; // R15
    ref_max_c = per_bank_mode ? 8'(lim_ab << (`RS_PB_SHIFT + 1)) : 8'(lim_ab << 1); // R12 R15
    // Window over five quarter-window slots covers every span of the real window length
    slot_len = ((int_ab << 1) > RFC_WIN ? (int_ab << 1) : RFC_WIN) >> 2; // R18
    enter_slow = (refresh_rate_code != rate_code_reg) &&
                 (refresh_rate_code == rs_refresh_pkg::RS_RATE_X4 || refresh_rate_code == rs_refresh_pkg::RS_RATE_X2);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-bank state: open flag, precharge and refresh-busy timers

  logic [NB-1:0] bank_open_reg;
  logic [NB-1:0] pre_busy;
  logic [NB-1:0] pb_busy;
  logic [NB-1:0] cand;
  logic [NB-1:0] blocked_next;
  logic issue_ab;
  logic issue_pb;
  logic [2:0] pick_bank;
  logic [NB-1:0] done_mask_reg;
  logic [3:0] rfcab_reg;
  logic [3:0] rfcab_next;

  genvar gb;
  generate
    for (gb = 0; gb < NB; gb++) begin : g_bank
      logic open_next;
      logic [3:0] pre_reg;
      logic [3:0] pre_next;
      logic [3:0] pbr_reg;
      logic [3:0] pbr_next;

      // Track what the controller did to this bank
      always_comb begin
        open_next = bank_open_reg[gb];
        if (act_issued && act_bank == 3'(gb)) begin
          open_next = 1'b1;
        end
        if (pre_issued && (pre_all || pre_bank == 3'(gb))) begin
          open_next = 1'b0;
        end
        pre_next = (pre_reg != 4'h0) ? pre_reg - 4'h1 : 4'h0;
        if (pre_issued && (pre_all || pre_bank == 3'(gb))) begin
          pre_next = RP_T; // R02 R07
        end
        pbr_next = (pbr_reg != 4'h0) ? pbr_reg - 4'h1 : 4'h0;
        if (issue_pb && pick_bank == 3'(gb)) begin
          pbr_next = RFCPB_T; // R03 R05
        end
        blocked_next[gb] = (pbr_next != 4'h0) || (rfcab_next != 4'h0); // R05 R08
      end

      always_ff @(posedge clk) begin
        if (rst) begin
          bank_open_reg[gb] <= 1'b0;
          pre_reg <= 4'h0;
          pbr_reg <= 4'h0;
        end else begin
          bank_open_reg[gb] <= open_next;
          pre_reg <= pre_next;
          pbr_reg <= pbr_next;
        end
      end

      assign pre_busy[gb] = (pre_reg != 4'h0);
      assign pb_busy[gb] = (pbr_reg != 4'h0);
      // Idle, precharged, not busy, not yet done this round
      assign cand[gb] = !bank_open_reg[gb] && !pre_busy[gb] && !pb_busy[gb] && !done_mask_reg[gb]; // R01 R22
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Refresh-rate window: slot counters form a sliding issue count

  logic [7:0] slot_cnt [NS];
  logic [7:0] slot_cnt_next [NS];
  logic [11:0] slot_tmr_reg;
  logic [11:0] slot_tmr_next;
  logic [7:0] window_sum;

  // Slot 0 is the current slot; expiring shifts the history along
  always_comb begin
    slot_tmr_next = slot_tmr_reg + 12'h001;
    window_sum = 8'h00;
    for (int k = 0; k < NS; k++) begin
      window_sum = window_sum + slot_cnt[k]; // R12
    end
    for (int k = 0; k < NS; k++) begin
      slot_cnt_next[k] = slot_cnt[k];
    end
    slot_cnt_next[0] = slot_cnt[0] + 8'((issue_ab || issue_pb) ? 1 : 0);
    if (slot_tmr_reg + 12'h001 >= slot_len) begin
      slot_tmr_next = 12'h000;
      for (int k = 1; k < NS; k++) begin
        slot_cnt_next[k] = slot_cnt[k-1];
      end
      slot_cnt_next[1] = slot_cnt_next[0];
      slot_cnt_next[0] = 8'h00;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      slot_tmr_reg <= 12'h000;
      for (int k = 0; k < NS; k++) begin
        slot_cnt[k] <= 8'h00;
      end
    end else begin
      slot_tmr_reg <= slot_tmr_next;
      for (int k = 0; k < NS; k++) begin
        slot_cnt[k] <= slot_cnt_next[k];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scheduler: interval tick, credit, global timers, issue choice

  logic [11:0] tick_reg;
  logic [11:0] tick_next;
  logic tick;
  logic signed [7:0] credit_reg;
  logic signed [7:0] credit_next;
  logic [3:0] rfcpb_reg;
  logic [3:0] rfcpb_next;
  logic [3:0] rrd_reg;
  logic [3:0] rrd_next;
  logic [2:0] pb_count_reg;
  logic [2:0] pb_count_next;
  logic [NB-1:0] done_mask_next;
  logic can_issue;
  logic want;

  always_comb begin
    // Interval clock stands still in self refresh, so the credit freezes
    tick = 1'b0;
    tick_next = tick_reg;
    if (!self_refresh_active) begin // R14
      tick_next = tick_reg + 12'h001;
      if (tick_reg + 12'h001 >= tick_len) begin // R09
        tick = 1'b1;
        tick_next = 12'h000;
      end
    end
    pick_bank = 3'h0;
    for (int k = NB - 1; k >= 0; k--) begin
      if (cand[k]) begin
        pick_bank = 3'(k);
      end
    end
    // A free slot with no other bank command beside it
    can_issue = cmd_slot_free && !act_issued && !pre_issued && !self_refresh_active && !self_refresh_exit_cmd &&
                (rfcab_reg == 4'h0) && (rfcpb_reg == 4'h0) && (window_sum < ref_max_c); // R02 R07 R08 R12
    // Owed refreshes go first; pull-ins only while they still earn credit
    want = (credit_reg > 8'sh00) || (pull_in_allow && credit_reg > -lim_c); // R11
    issue_ab = can_issue && want && !per_bank_mode && (bank_open_reg == '0) && (pre_busy == '0); // R06 R07
    issue_pb = can_issue && want && per_bank_mode && (rrd_reg == 4'h0) && (cand != '0); // R01 R02
    credit_next = credit_reg + 8'(tick ? 1 : 0) - 8'((issue_ab || issue_pb) ? 1 : 0); // R25
    if (credit_next < -lim_c) begin
      credit_next = -lim_c; // R11
    end
    if (enter_slow && credit_next < 8'sh00) begin
      credit_next = 8'sh00; // R19
    end
    rfcab_next = issue_ab ? RFCAB_T : ((rfcab_reg != 4'h0) ? rfcab_reg - 4'h1 : 4'h0); // R08
    rfcpb_next = issue_pb ? RFCPB_T : ((rfcpb_reg != 4'h0) ? rfcpb_reg - 4'h1 : 4'h0); // R05
    rrd_next = act_issued ? RRD_T : ((rrd_reg != 4'h0) ? rrd_reg - 4'h1 : 4'h0); // R02
    pb_count_next = pb_count_reg;
    done_mask_next = done_mask_reg;
    if (issue_pb) begin
      pb_count_next = pb_count_reg + 3'h1; // R21
      done_mask_next = done_mask_reg | (8'h01 << pick_bank); // R22
      if ((done_mask_reg | (8'h01 << pick_bank)) == 8'hff) begin
        done_mask_next = 8'h00;
      end
    end
    if (issue_ab || self_refresh_exit_cmd) begin
      pb_count_next = 3'h0; // R21 R24
      done_mask_next = 8'h00;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tick_reg <= 12'h000;
      credit_reg <= 8'sh00;
      rfcab_reg <= 4'h0;
      rfcpb_reg <= 4'h0;
      rrd_reg <= 4'h0;
      pb_count_reg <= 3'h0;
      done_mask_reg <= 8'h00;
      rate_code_reg <= 3'h0;
      all_bank_refresh_cmd <= 1'b0;
      per_bank_refresh_cmd <= 1'b0;
      bank_addr_bit0 <= 1'b0;
      bank_addr_bit1 <= 1'b0;
      bank_addr_bit2 <= 1'b0;
      refresh_urgent <= 1'b0;
      bank_blocked <= 8'h00;
      refresh_credit <= 8'h00;
    end else begin
      tick_reg <= tick_next;
      credit_reg <= credit_next;
      rfcab_reg <= rfcab_next;
      rfcpb_reg <= rfcpb_next;
      rrd_reg <= rrd_next;
      pb_count_reg <= pb_count_next;
      done_mask_reg <= done_mask_next;
      rate_code_reg <= refresh_rate_code;
      all_bank_refresh_cmd <= issue_ab;
      per_bank_refresh_cmd <= issue_pb;
      bank_addr_bit0 <= pick_bank[0]; // R23
      bank_addr_bit1 <= pick_bank[1];
      bank_addr_bit2 <= pick_bank[2];
      // Postponement at its limit: also bars self-refresh entry growth
      refresh_urgent <= (credit_next >= lim_c); // R10 R13
      bank_blocked <= blocked_next; // R03
      refresh_credit <= credit_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_pb_target_idle: assert property (@(posedge clk) disable iff (rst) // R01
    per_bank_refresh_cmd |-> (($past(bank_open_reg) >> {bank_addr_bit2, bank_addr_bit1, bank_addr_bit0}) & 8'h01) == 8'h00)
    else $error("per-bank refresh to an open bank");
  a_ab_spacing: assert property (@(posedge clk) disable iff (rst) // R08
    all_bank_refresh_cmd |=> !(all_bank_refresh_cmd || per_bank_refresh_cmd) [*5])
    else $error("refresh inside all-bank cycle time");
  a_pb_spacing: assert property (@(posedge clk) disable iff (rst) // R05
    per_bank_refresh_cmd |=> !(all_bank_refresh_cmd || per_bank_refresh_cmd) [*2])
    else $error("refresh inside per-bank cycle time");
  a_act_no_ab: assert property (@(posedge clk) disable iff (rst) // R06
    act_issued |=> !all_bank_refresh_cmd)
    else $error("all-bank refresh right after activate");
  a_credit_floor: assert property (@(posedge clk) disable iff (rst) // R11
    credit_reg >= -lim_c || $past(refresh_rate_code) != refresh_rate_code)
    else $error("pull-in credit past its limit");
  a_window_cap: assert property (@(posedge clk) disable iff (rst) // R12
    (all_bank_refresh_cmd || per_bank_refresh_cmd) |-> $past(window_sum) < $past(ref_max_c))
    else $error("too many refreshes in window");
  a_sr_freeze: assert property (@(posedge clk) disable iff (rst) // R14
    self_refresh_active && $past(self_refresh_active) && !$past(enter_slow) |-> $stable(credit_reg))
    else $error("credit moved in self refresh");
  a_slow_drop: assert property (@(posedge clk) disable iff (rst) // R19
    enter_slow |=> credit_reg >= 8'sh00)
    else $error("pulled-in count kept across slower rate");
  a_ab_sync: assert property (@(posedge clk) disable iff (rst) // R21
    all_bank_refresh_cmd |-> pb_count_reg == 3'h0 && done_mask_reg == 8'h00)
    else $error("bank counter not cleared by all-bank refresh");
  a_round_unique: assert property (@(posedge clk) disable iff (rst) // R22
    per_bank_refresh_cmd |-> (($past(done_mask_reg) >> {bank_addr_bit2, bank_addr_bit1, bank_addr_bit0}) & 8'h01) == 8'h00)
    else $error("bank refreshed twice in one round");

endmodule : rs_refresh_sched

// file: verification/rs_dev_model.sv
/*
  Behavioural model of one eight-bank channel that receives the refresh
  scheduler's commands: bank state, refresh cycle timers, bank and row
  counters, and a count of protocol faults committed by the controller.
  Assumes commands are one-cycle pulses sampled on the rising edge of clk.
*/
module rs_dev_model #(
  parameter int RFCAB_CYC = 6,
  parameter int RFCPB_CYC = 3
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ab_cmd,
  input wire logic pb_cmd,
  input wire logic [2:0] pb_bank,
  input wire logic act,
  input wire logic [2:0] act_bank,
  input wire logic pre,
  input wire logic [2:0] pre_bank,
  input wire logic pre_all,
  input wire logic sr_exit,
  output logic [7:0] err_cnt,
  output logic [2:0] bank_cnt,
  output logic [15:0] row_cnt
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] open_q;
  logic [7:0] done_q;
  int ab_left;
  int pb_left;
  int blk [8];

  ////////////////////////////////////////////////////////////////////////////
  // Faults are counted, not fatal, so one run shows every one of them
  always @(posedge clk) begin
    if (rst) begin
      open_q = 8'h00;
      done_q = 8'h00;
      ab_left = 0;
      pb_left = 0;
      blk = '{default: 0};
      err_cnt = 8'h00;
      bank_cnt = 3'h0;
      row_cnt = 16'h0000;
    end else begin
      if (ab_cmd && (open_q != 8'h00 || ab_left > 0 || pb_left > 0)) err_cnt++;
      if (pb_cmd && (open_q[pb_bank] || ab_left > 0 || pb_left > 0 || done_q[pb_bank])) err_cnt++;
      if (act && (ab_left > 0 || blk[act_bank] > 0)) err_cnt++;
      // Timers run down; an expired bank timer means the bank is idle again
      if (ab_left > 0) ab_left--;
      if (pb_left > 0) pb_left--;
      for (int b = 0; b < 8; b++) begin
        if (blk[b] > 0) blk[b]--;
      end
      if (ab_cmd) begin
        ab_left = RFCAB_CYC - 1;
        blk = '{default: RFCAB_CYC - 1};
        bank_cnt = 3'h0;
        done_q = 8'h00;
        row_cnt++;
      end
      if (pb_cmd) begin
        pb_left = RFCPB_CYC - 1;
        blk[pb_bank] = RFCPB_CYC - 1;
        done_q[pb_bank] = 1'b1;
        if (bank_cnt == 3'h7) row_cnt++;
        bank_cnt++;
        if (done_q == 8'hff) done_q = 8'h00;
      end
      if (sr_exit) begin
        bank_cnt = 3'h0;
        done_q = 8'h00;
      end
      if (act) open_q[act_bank] = 1'b1;
      if (pre) open_q = pre_all ? 8'h00 : (open_q & ~(8'h01 << pre_bank));
    end
  end
endmodule : rs_dev_model

// file: verification/tb_rs_refresh_sched.sv
/*
  Self-checking bench of the refresh scheduler with a channel model.
  Assumes default timing parameters: 78-cycle base interval, all-bank
  cycle 6, per-bank cycle 3, precharge and act-to-act 1 cycle.
*/
module tb_rs_refresh_sched;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] refresh_rate_code = 3'h3;
  logic per_bank_mode = 1'b0;
  logic pull_in_allow = 1'b0;
  logic self_refresh_active = 1'b0;
  logic self_refresh_exit_cmd = 1'b0;
  logic cmd_slot_free = 1'b0;
  logic act_issued = 1'b0;
  logic [2:0] act_bank = 3'h0;
  logic pre_issued = 1'b0;
  logic [2:0] pre_bank = 3'h0;
  logic pre_all = 1'b0;
  logic all_bank_refresh_cmd, per_bank_refresh_cmd;
  logic bank_addr_bit0, bank_addr_bit1, bank_addr_bit2, refresh_urgent;
  logic [7:0] bank_blocked, refresh_credit, err_cnt;
  logic [2:0] bank_cnt;
  logic [15:0] row_cnt;
  int fails = 0;
  int n_checks = 0;

  rs_refresh_sched i_rs_refresh_sched (.clk(clk), .rst(rst), .refresh_rate_code(refresh_rate_code),
    .per_bank_mode(per_bank_mode), .pull_in_allow(pull_in_allow), .self_refresh_active(self_refresh_active),
    .self_refresh_exit_cmd(self_refresh_exit_cmd), .cmd_slot_free(cmd_slot_free), .act_issued(act_issued),
    .act_bank(act_bank), .pre_issued(pre_issued), .pre_bank(pre_bank), .pre_all(pre_all),
    .all_bank_refresh_cmd(all_bank_refresh_cmd), .per_bank_refresh_cmd(per_bank_refresh_cmd),
    .bank_addr_bit0(bank_addr_bit0), .bank_addr_bit1(bank_addr_bit1), .bank_addr_bit2(bank_addr_bit2),
    .refresh_urgent(refresh_urgent), .bank_blocked(bank_blocked), .refresh_credit(refresh_credit));

  rs_dev_model #(.RFCAB_CYC(6), .RFCPB_CYC(3)) i_rs_dev_model (.clk(clk), .rst(rst),
    .ab_cmd(all_bank_refresh_cmd), .pb_cmd(per_bank_refresh_cmd),
    .pb_bank({bank_addr_bit2, bank_addr_bit1, bank_addr_bit0}), .act(act_issued), .act_bank(act_bank),
    .pre(pre_issued), .pre_bank(pre_bank), .pre_all(pre_all), .sr_exit(self_refresh_exit_cmd),
    .err_cnt(err_cnt), .bank_cnt(bank_cnt), .row_cnt(row_cnt));

  initial begin
    forever #25 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Inputs change 1 ns after the edge, so outputs read then are settled
  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick

  task automatic results();
    if (fails == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : results

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk

  task automatic rst_dut(input logic [2:0] code);
    {per_bank_mode, pull_in_allow, cmd_slot_free} = 3'h0;
    refresh_rate_code = code;
    rst = 1'b1;
    repeat (4) tick();
    rst = 1'b0;
    chk("cmds in reset", {all_bank_refresh_cmd, per_bank_refresh_cmd}, 0);
    chk("blocked in reset", bank_blocked, 0);
    chk("credit in reset", refresh_credit, 0);
    chk("bank count", bank_cnt, 0);
  endtask : rst_dut

  // Both waits give up after lim cycles and close the run as failed
  task automatic wait_cmd(input logic pb, input int lim, output int c);
    for (c = 1; c <= lim; c++) begin
      tick();
      if ((pb ? per_bank_refresh_cmd : all_bank_refresh_cmd) === 1'b1) return;
    end
    chk("refresh timeout", 0, 1);
    results();
  endtask : wait_cmd

  task automatic wait_credit(input logic [7:0] v, input int lim);
    for (int c = 0; c < lim; c++) begin
      tick();
      if (refresh_credit === v) return;
    end
    chk("credit timeout", refresh_credit, v);
    results();
  endtask : wait_credit

  ////////////////////////////////////////////////////////////////////////////
  // Every rate code: postponement limit, urgency and interval length
  task automatic s_limits();
    logic [7:0] lim [8] = '{8'h02, 8'h02, 8'h04, 8'h08, 8'h08, 8'h08, 8'h08, 8'h08};
    int per [8] = '{312, 312, 156, 78, 39, 19, 19, 19};
    int c;
    for (int i = 0; i < 8; i++) begin
      rst_dut(3'(i));
      wait_credit(lim[i], 700);
      tick();
      chk("urgent at limit", refresh_urgent, 1);
      for (c = 1; c < 400 && refresh_credit === lim[i]; c++) tick();
      chk("interval", 16'(c), 16'(per[i]));
    end
  endtask : s_limits

  // All-bank refresh held off by an open bank, then blocks all banks
  task automatic s_allbank();
    int c;
    rst_dut(3'h3);
    act_issued = 1'b1;
    act_bank = 3'h2;
    tick();
    act_issued = 1'b0;
    wait_credit(8'h01, 100);
    cmd_slot_free = 1'b1;
    repeat (10) begin
      tick();
      chk("refresh while open", all_bank_refresh_cmd, 0);
    end
    {pre_issued, pre_all} = 2'b11;
    tick();
    {pre_issued, pre_all} = 2'b00;
    wait_cmd(1'b0, 6, c);
    chk("credit after", refresh_credit, 0);
    for (int k = 1; k <= 6; k++) begin
      chk("all blocked", bank_blocked, 8'hff);
      tick();
      chk("no refresh in cycle", all_bank_refresh_cmd, 0);
    end
    chk("all released", bank_blocked, 8'h00);
    // Channel model takes the pulse one edge after it shows
    chk("row count", row_cnt, 1);
  endtask : s_allbank

  // A round of per-bank refreshes, an open bank skipped, resync by exit
  task automatic s_perbank();
    int c;
    rst_dut(3'h3);
    {per_bank_mode, pull_in_allow, cmd_slot_free} = 3'h7;
    for (int k = 0; k < 8; k++) begin
      wait_cmd(1'b1, 40, c);
      chk("bank address", {bank_addr_bit2, bank_addr_bit1, bank_addr_bit0}, 16'(k));
      chk("bank blocked", bank_blocked, 8'h01 << k);
      if (k > 0) chk("spacing", c >= 3, 1);
    end
    act_issued = 1'b1;
    act_bank = 3'h0;
    tick();
    act_issued = 1'b0;
    wait_cmd(1'b1, 40, c);
    chk("open bank skipped", {bank_addr_bit2, bank_addr_bit1, bank_addr_bit0}, 1);
    cmd_slot_free = 1'b0;
    self_refresh_exit_cmd = 1'b1;
    tick();
    self_refresh_exit_cmd = 1'b0;
    pre_issued = 1'b1;
    tick();
    pre_issued = 1'b0;
    repeat (2) tick();
    cmd_slot_free = 1'b1;
    wait_cmd(1'b1, 20, c);
    chk("bank after resync", {bank_addr_bit2, bank_addr_bit1, bank_addr_bit0}, 0);
    tick();
    chk("model bank count", bank_cnt, 1);
  endtask : s_perbank

  // Pull-in floor, window cap and thermal step into the four-times rate
  task automatic s_pullin();
    int n = 0;
    int mn = 0;
    rst_dut(3'h3);
    {pull_in_allow, cmd_slot_free} = 2'b11;
    for (int c = 0; c < 360; c++) begin
      tick();
      if (c < 156 && all_bank_refresh_cmd === 1'b1) n++;
      if (int'($signed(refresh_credit)) < mn) mn = int'($signed(refresh_credit));
    end
    chk("refreshes in window", n <= 16, 1);
    chk("credit floor", mn[15:0], 16'hfff8);
    chk("pulled in before", refresh_credit[7], 1);
    // Pull-ins stop, else a fresh early refresh moves the credit again
    pull_in_allow = 1'b0;
    refresh_rate_code = 3'h1;
    repeat (2) tick();
    chk("pulled-in dropped", refresh_credit, 0);
  endtask : s_pullin

  // Self refresh freezes the credit and blocks issue
  task automatic s_selfref();
    int n = 0;
    int c;
    rst_dut(3'h3);
    wait_credit(8'h01, 100);
    self_refresh_active = 1'b1;
    cmd_slot_free = 1'b1;
    repeat (200) begin
      tick();
      n += all_bank_refresh_cmd;
    end
    chk("credit frozen", refresh_credit, 1);
    chk("no issue in self refresh", 16'(n), 0);
    self_refresh_active = 1'b0;
    self_refresh_exit_cmd = 1'b1;
    tick();
    self_refresh_exit_cmd = 1'b0;
    wait_cmd(1'b0, 10, c);
    chk("bank count after exit", bank_cnt, 0);
  endtask : s_selfref

  initial begin
    s_limits();
    s_allbank();
    s_perbank();
    s_pullin();
    s_selfref();
    chk("channel faults", err_cnt, 0);
    results();
  end
endmodule : tb_rs_refresh_sched
